// file: inc/timer_pkg.sv
// constants, carriers and state layout of the dual timer block
// assumes one 32-bit ahb-lite slave port and one peripheral clock
package timer_pkg;
  localparam int unsigned DW          = 32;
  localparam int unsigned AW          = 8;
  localparam int unsigned CTRL_W      = 9;
  localparam int unsigned EVT_W       = 4;
  localparam int unsigned PRESCALE_W  = 5;
  localparam int unsigned BAUD_W      = 5;
  localparam int unsigned PCLK_PER_MC = 2;
  localparam int unsigned HTRANS_ACT  = 1;

  localparam logic [AW-1:0] OFS_CTRL      = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS    = 8'h04;
  localparam logic [AW-1:0] OFS_MASK      = 8'h08;
  localparam logic [AW-1:0] OFS_FIRST_LOW = 8'h0c;
  localparam logic [AW-1:0] OFS_FIRST_HI  = 8'h10;
  localparam logic [AW-1:0] OFS_SECOND_LO = 8'h14;
  localparam logic [AW-1:0] OFS_SECOND_RL = 8'h18;

  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;
  localparam logic [1:0] UART_VAR_A  = 2'h1;
  localparam logic [1:0] UART_VAR_B  = 2'h3;

  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 5'h1f;
  localparam logic [PRESCALE_W-1:0] PRESCALE_ONE  = 5'h01;
  localparam logic [BAUD_W-1:0]     BAUD_LAST_1X  = 5'h1f;
  localparam logic [BAUD_W-1:0]     BAUD_LAST_2X  = 5'h0f;
  localparam logic [BAUD_W-1:0]     BAUD_ONE      = 5'h01;
  localparam logic [7:0]            BYTE_ONES     = 8'hff;
  localparam logic [7:0]            BYTE_ONE      = 8'h01;
  localparam logic [15:0]           WORD_ONE      = 16'h0001;
  localparam logic                  MC_LAST       = 1'(PCLK_PER_MC - 1);

  typedef struct packed {
    logic       baud_double_select;
    logic       baud_src_sel;
    logic       pin_count_first;
    logic       run_second;
    logic       run_first;
    logic [1:0] mode_second;
    logic [1:0] mode_first;
  } ctrl_t;

  typedef struct packed {
    logic baud;
    logic second_ovf;
    logic first_high_ovf;
    logic first_low_ovf;
  } events_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DATA = 2'b10
  } bus_phase_t;

  typedef struct packed {
    bus_phase_t        phase;
    logic              write;
    logic [AW-1:0]     addr;
    ctrl_t             ctrl;
    events_t           status;
    events_t           mask;
    logic [7:0]        first_low;
    logic [7:0]        first_high;
    logic [7:0]        second_low;
    logic [7:0]        second_reload;
    logic              mc;
    logic [BAUD_W-1:0] baud_div;
    logic [DW-1:0]     rdata;
    logic              ready;
    logic              resp;
    logic              irq;
    logic              first_ovf_p;
    logic              second_ovf_p;
    logic              baud_p;
  } timer_state_t;
endpackage

// file: verilog/pin_fall_detect.sv
// falling edge detector for the external count pin
// assumes the pin is already synchronous to clock_in
module pin_fall_detect
  import timer_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic sys_rst_in,
  input  wire logic pin_in,
  output logic      fall_out
);
  logic prev;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prev <= 1'b0;
    end else begin
      prev <= pin_in;
    end
  end

  // one-to-zero transition
  assign fall_out = prev & ~pin_in; // RULE2
endmodule

// file: verilog/timer_count_step.sv
// next-count logic of one timer for one increment
// assumes the caller gates inc_in and handles split-mode high byte
module timer_count_step
  import timer_pkg::*;
(
  input  wire logic [1:0] mode_in,
  input  wire logic       inc_in,
  input  wire logic [7:0] low_in,
  input  wire logic [7:0] high_in,
  output logic [7:0]      low_out,
  output logic [7:0]      high_out,
  output logic            ovf_out
);
  always_comb begin
    low_out  = low_in;
    high_out = high_in;
    ovf_out  = 1'b0;
    if (inc_in) begin
      unique case (mode_in)
        MODE_13BIT: begin
          // divide-by-32 prescaler ahead of the high byte
          if (low_in[PRESCALE_W-1:0] == PRESCALE_LAST) begin // RULE3
            low_out[PRESCALE_W-1:0] = '0;
            high_out                = high_in + BYTE_ONE;
            ovf_out                 = (high_in == BYTE_ONES); // RULE12
          end else begin
            low_out[PRESCALE_W-1:0] = low_in[PRESCALE_W-1:0] + PRESCALE_ONE;
          end
        end
        MODE_16BIT: begin
          {high_out, low_out} = {high_in, low_in} + WORD_ONE; // RULE4
          ovf_out             = (low_in == BYTE_ONES) && (high_in == BYTE_ONES);
        end
        MODE_RELOAD: begin
          low_out = (low_in == BYTE_ONES) ? high_in : low_in + BYTE_ONE; // RULE5
          ovf_out = (low_in == BYTE_ONES);
        end
        MODE_SPLIT: begin
          low_out = low_in + BYTE_ONE; // RULE6
          ovf_out = (low_in == BYTE_ONES);
        end
      endcase
    end
  end
endmodule

// file: verilog/dual_timer_counter_baud.sv
// two count-up timers with baud clock output, ahb-lite register slave
// assumes a single slave on the bus, hready_in tied to hreadyout_out
// Function
// [RULE1] Each timer counts up by one per machine cycle of two peripheral clocks.
// [RULE2] The first timer may count falling edges of its count pin instead.
// [RULE3] Mode 0 is an 8-bit counter behind a divide-by-32 prescaler.
// [RULE4] Mode 1 joins low and high bytes into one 16-bit counter.
// [RULE5] Mode 2 counts the low byte and reloads it from the high byte on overflow.
// [RULE6] Mode 3 splits the first timer into two independent 8-bit counters.
// [RULE7] The second timer in mode 3 halts and keeps its count even when running.
// [RULE8] In modes 0 to 2 the timers run independently, each with its own mode.
// [RULE9] In uart modes 1 and 3 the second timer overflow can be chosen as baud clock.
// [RULE10] Software should use mode 2 with the reload byte set for the baud rate.
// [RULE11] Baud rate is two to the double bit times pclk over 64 times (256 minus reload).
// [RULE12] Overflow wraps to zero or the reload value and gives a one-cycle pulse.
module dual_timer_counter_baud
  import timer_pkg::*;
(
  input  wire logic          clock_in,
  input  wire logic          sys_rst_in,
  input  wire logic          hsel_in,
  input  wire logic [DW-1:0] haddr_in,
  input  wire logic [1:0]    htrans_in,
  input  wire logic          hwrite_in,
  input  wire logic [2:0]    hsize_in,
  input  wire logic [DW-1:0] hwdata_in,
  input  wire logic          hready_in,
  output logic [DW-1:0]      hrdata_out,
  output logic               hreadyout_out,
  output logic               hresp_out,
  input  wire logic          first_timer_count_pin_in,
  input  wire logic [1:0]    uart_mode_in,
  output logic               irq_out,
  output logic               first_timer_ovf_out,
  output logic               second_timer_ovf_out,
  output logic               baud_tick_out
);
  timer_state_t      st;
  timer_state_t      next_st;
  logic              fall;
  logic              tick;
  logic              inc_first;
  logic              inc_split_high;
  logic              inc_second;
  logic              split_first;
  logic [7:0]        step0_low;
  logic [7:0]        step0_high;
  logic [7:0]        step1_low;
  logic [7:0]        step1_high;
  logic              ovf0;
  logic              ovf1;
  logic              ovf_split_high;
  logic              baud_enable;
  logic [BAUD_W-1:0] baud_last;
  logic              baud_hit;
  logic              wr;
  logic              take;
  events_t           evt;
  events_t           clear;

  pin_fall_detect u_pin (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (first_timer_count_pin_in),
    .fall_out   (fall)
  );

  timer_count_step u_first (
    .mode_in  (st.ctrl.mode_first),
    .inc_in   (inc_first),
    .low_in   (st.first_low),
    .high_in  (st.first_high),
    .low_out  (step0_low),
    .high_out (step0_high),
    .ovf_out  (ovf0)
  );

  timer_count_step u_second (
    .mode_in  (st.ctrl.mode_second),
    .inc_in   (inc_second),
    .low_in   (st.second_low),
    .high_in  (st.second_reload),
    .low_out  (step1_low),
    .high_out (step1_high),
    .ovf_out  (ovf1)
  );

  // machine cycle strobe, one every two clocks
  assign tick           = (st.mc == MC_LAST); // RULE1
  assign split_first    = (st.ctrl.mode_first == MODE_SPLIT);
  assign inc_first      = st.ctrl.run_first & (st.ctrl.pin_count_first ? fall : tick); // RULE2
  assign inc_split_high = split_first & st.ctrl.run_second & tick; // RULE6
  assign inc_second     = st.ctrl.run_second & tick & (st.ctrl.mode_second != MODE_SPLIT); // RULE7 RULE8
  assign ovf_split_high = inc_split_high & (st.first_high == BYTE_ONES);

  // baud clock from second timer overflow
  assign baud_enable = st.ctrl.baud_src_sel & ((uart_mode_in == UART_VAR_A) | (uart_mode_in == UART_VAR_B)); // RULE9
  assign baud_last   = st.ctrl.baud_double_select ? BAUD_LAST_2X : BAUD_LAST_1X; // RULE11
  assign baud_hit    = baud_enable & ovf1 & (st.baud_div == baud_last); // RULE11

  assign wr   = (st.phase == BUS_DATA) & st.write;
  assign take = hsel_in & htrans_in[HTRANS_ACT] & hready_in;

  assign evt.first_low_ovf  = ovf0;
  assign evt.first_high_ovf = ovf_split_high;
  assign evt.second_ovf     = ovf1;
  assign evt.baud           = baud_hit;
  assign clear              = (wr && st.addr == OFS_STATUS) ? events_t'(hwdata_in[EVT_W-1:0]) : '0;

  always_comb begin
    logic [DW-1:0] rd;
    rd      = '0;
    next_st = st;
    next_st.mc = (st.mc == MC_LAST) ? 1'b0 : ~st.mc; // RULE1

    // counting
    next_st.first_low  = step0_low;
    next_st.first_high = split_first ? st.first_high + BYTE_ONE * inc_split_high : step0_high; // RULE6
    next_st.second_low    = step1_low; // RULE12
    next_st.second_reload = step1_high;

    // baud divider
    if (!baud_enable) begin
      next_st.baud_div = '0;
    end else if (ovf1) begin
      next_st.baud_div = baud_hit ? '0 : st.baud_div + BAUD_ONE; // RULE11
    end

    // sticky status, set beats clear
    next_st.status = (st.status & ~clear) | evt;

    // bus data phase and address phase
    next_st.ready = 1'b1;
    next_st.resp  = 1'b0;
    if (st.phase == BUS_DATA) begin
      unique case (st.addr)
        OFS_CTRL:      rd = DW'(st.ctrl);
        OFS_STATUS:    rd = DW'(st.status);
        OFS_MASK:      rd = DW'(st.mask);
        OFS_FIRST_LOW: rd = DW'(st.first_low);
        OFS_FIRST_HI:  rd = DW'(st.first_high);
        OFS_SECOND_LO: rd = DW'(st.second_low);
        OFS_SECOND_RL: rd = DW'(st.second_reload);
        default:       rd = '0;
      endcase
      next_st.rdata = st.write ? st.rdata : rd;
      next_st.phase = BUS_IDLE;
      if (st.write) begin
        unique case (st.addr)
          OFS_CTRL:      next_st.ctrl          = ctrl_t'(hwdata_in[CTRL_W-1:0]);
          OFS_MASK:      next_st.mask          = events_t'(hwdata_in[EVT_W-1:0]);
          OFS_FIRST_LOW: next_st.first_low     = hwdata_in[7:0];
          OFS_FIRST_HI:  next_st.first_high    = hwdata_in[7:0];
          OFS_SECOND_LO: next_st.second_low    = hwdata_in[7:0];
          OFS_SECOND_RL: next_st.second_reload = hwdata_in[7:0];
          default:       next_st.rdata         = st.rdata;
        endcase
      end
    end else if (take) begin
      next_st.phase = BUS_DATA;
      next_st.write = hwrite_in;
      next_st.addr  = haddr_in[AW-1:0];
      next_st.ready = 1'b0;
    end

    // registered outputs
    next_st.irq          = |(next_st.status & next_st.mask);
    next_st.first_ovf_p  = ovf0 | ovf_split_high; // RULE12
    next_st.second_ovf_p = ovf1; // RULE12
    next_st.baud_p       = baud_hit; // RULE9
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st       <= '0;
      st.phase <= BUS_IDLE;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata_out           = st.rdata;
  assign hreadyout_out        = st.ready;
  assign hresp_out            = st.resp;
  assign irq_out              = st.irq;
  assign first_timer_ovf_out  = st.first_ovf_p;
  assign second_timer_ovf_out = st.second_ovf_p;
  assign baud_tick_out        = st.baud_p;

  // checks
  property p_mc_alternate;
    @(posedge clock_in) disable iff (sys_rst_in)
      tick |=> !tick ##1 tick;
  endproperty
  a_mc_alternate: assert property (p_mc_alternate) else $error("machine cycle not every two clocks"); // RULE1

  property p_second_counts;
    @(posedge clock_in) disable iff (sys_rst_in)
      (st.ctrl.mode_second == MODE_16BIT) && st.ctrl.run_second && !wr && tick && (st.second_low != BYTE_ONES)
      |=> (st.second_low == 8'($past(st.second_low) + BYTE_ONE)) ##1 $stable(st.second_low) || $past(wr);
  endproperty
  a_second_counts: assert property (p_second_counts) else $error("second timer did not step once"); // RULE1

  property p_pin_counts;
    @(posedge clock_in) disable iff (sys_rst_in)
      st.ctrl.pin_count_first && st.ctrl.run_first && (st.ctrl.mode_first != MODE_13BIT) && fall && !wr
      && (st.first_low != BYTE_ONES) |=> st.first_low == 8'($past(st.first_low) + BYTE_ONE);
  endproperty
  a_pin_counts: assert property (p_pin_counts) else $error("pin falling edge not counted"); // RULE2

  property p_prescale;
    @(posedge clock_in) disable iff (sys_rst_in)
      (st.ctrl.mode_first == MODE_13BIT) && inc_first && !wr && (st.first_low[PRESCALE_W-1:0] == PRESCALE_LAST)
      |=> (st.first_high == 8'($past(st.first_high) + BYTE_ONE)) && (st.first_low[PRESCALE_W-1:0] == '0);
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler carry missing"); // RULE3

  property p_carry16;
    @(posedge clock_in) disable iff (sys_rst_in)
      (st.ctrl.mode_second == MODE_16BIT) && inc_second && !wr && (st.second_low == BYTE_ONES)
      |=> (st.second_reload == 8'($past(st.second_reload) + BYTE_ONE)) && (st.second_low == '0);
  endproperty
  a_carry16: assert property (p_carry16) else $error("16-bit carry wrong"); // RULE4

  property p_reload;
    @(posedge clock_in) disable iff (sys_rst_in)
      (st.ctrl.mode_second == MODE_RELOAD) && inc_second && !wr && (st.second_low == BYTE_ONES)
      |=> (st.second_low == $past(st.second_reload)) && $stable(st.second_reload);
  endproperty
  a_reload: assert property (p_reload) else $error("auto-reload wrong"); // RULE5

  property p_split_high;
    @(posedge clock_in) disable iff (sys_rst_in)
      inc_split_high && !inc_first && !wr
      |=> (st.first_high == 8'($past(st.first_high) + BYTE_ONE)) && $stable(st.first_low);
  endproperty
  a_split_high: assert property (p_split_high) else $error("split high byte not independent"); // RULE6

  property p_second_halt;
    @(posedge clock_in) disable iff (sys_rst_in)
      (st.ctrl.mode_second == MODE_SPLIT) && !wr |=> $stable(st.second_low) && $stable(st.second_reload);
  endproperty
  a_second_halt: assert property (p_second_halt) else $error("second timer moved in mode 3"); // RULE7

  property p_independent;
    @(posedge clock_in) disable iff (sys_rst_in)
      !split_first && !st.ctrl.run_first && !wr |=> $stable(st.first_low) && $stable(st.first_high);
  endproperty
  a_independent: assert property (p_independent) else $error("first timer moved while stopped"); // RULE8

  property p_baud_gate;
    @(posedge clock_in) disable iff (sys_rst_in)
      baud_tick_out |-> $past(baud_enable) && $past(ovf1);
  endproperty
  a_baud_gate: assert property (p_baud_gate) else $error("baud tick without source"); // RULE9

  property p_baud_div;
    @(posedge clock_in) disable iff (sys_rst_in)
      baud_enable && ovf1 && !baud_hit |=> st.baud_div == BAUD_W'($past(st.baud_div) + BAUD_ONE) && !baud_tick_out;
  endproperty
  a_baud_div: assert property (p_baud_div) else $error("baud divider step wrong"); // RULE11

  property p_ovf_pulse;
    @(posedge clock_in) disable iff (sys_rst_in)
      ovf1 |=> second_timer_ovf_out && st.status.second_ovf ##1 !second_timer_ovf_out;
  endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse not one cycle"); // RULE12

  property p_first_mc_hold;
    @(posedge clock_in) disable iff (sys_rst_in)
      st.ctrl.run_first && !st.ctrl.pin_count_first && !tick && !wr
      |=> $stable(st.first_low) && $stable(st.first_high);
  endproperty
  a_first_mc_hold: assert property (p_first_mc_hold) else $error("first timer stepped off tick"); // RULE1

  property p_second_mc_hold;
    @(posedge clock_in) disable iff (sys_rst_in)
      st.ctrl.run_second && !tick && !wr
      |=> $stable(st.second_low) && $stable(st.second_reload);
  endproperty
  a_second_mc_hold: assert property (p_second_mc_hold) else $error("second timer stepped off tick"); // RULE1

  property p_pin_hold;
    @(posedge clock_in) disable iff (sys_rst_in)
      st.ctrl.pin_count_first && st.ctrl.run_first && !fall && !wr
      |=> $stable(st.first_low);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("first timer stepped without pin edge"); // RULE2

  property p_prescale_step;
    @(posedge clock_in) disable iff (sys_rst_in)
      (st.ctrl.mode_first == MODE_13BIT) && inc_first && !wr && (st.first_low[PRESCALE_W-1:0] != PRESCALE_LAST)
      |=> $stable(st.first_high)
          && (st.first_low[PRESCALE_W-1:0] == PRESCALE_W'($past(st.first_low[PRESCALE_W-1:0]) + PRESCALE_ONE));
  endproperty
  a_prescale_step: assert property (p_prescale_step) else $error("prescaler step wrong"); // RULE3

  property p_first_carry16;
    @(posedge clock_in) disable iff (sys_rst_in)
      (st.ctrl.mode_first == MODE_16BIT) && inc_first && !wr
      |=> {st.first_high, st.first_low} == 16'({$past(st.first_high), $past(st.first_low)} + WORD_ONE);
  endproperty
  a_first_carry16: assert property (p_first_carry16) else $error("first 16-bit step wrong"); // RULE4

  property p_first_reload;
    @(posedge clock_in) disable iff (sys_rst_in)
      (st.ctrl.mode_first == MODE_RELOAD) && inc_first && !wr && (st.first_low == BYTE_ONES)
      |=> (st.first_low == $past(st.first_high)) && $stable(st.first_high);
  endproperty
  a_first_reload: assert property (p_first_reload) else $error("first auto-reload wrong"); // RULE5

  property p_split_ovf;
    @(posedge clock_in) disable iff (sys_rst_in)
      ovf_split_high
      |=> first_timer_ovf_out && st.status.first_high_ovf;
  endproperty
  a_split_ovf: assert property (p_split_ovf) else $error("split high overflow lost"); // RULE6

  property p_second_steps;
    @(posedge clock_in) disable iff (sys_rst_in)
      (st.ctrl.mode_second == MODE_RELOAD) && inc_second && !wr && (st.second_low != BYTE_ONES)
      |=> (st.second_low == 8'($past(st.second_low) + BYTE_ONE)) && $stable(st.second_reload);
  endproperty
  a_second_steps: assert property (p_second_steps) else $error("second timer step wrong"); // RULE8

  property p_baud_idle;
    @(posedge clock_in) disable iff (sys_rst_in)
      !baud_enable
      |=> (st.baud_div == '0) && !baud_tick_out;
  endproperty
  a_baud_idle: assert property (p_baud_idle) else $error("baud divider active while deselected"); // RULE9

  property p_baud_tick;
    @(posedge clock_in) disable iff (sys_rst_in)
      baud_enable && ovf1 && (st.baud_div == (st.ctrl.baud_double_select ? BAUD_LAST_2X : BAUD_LAST_1X))
      |=> baud_tick_out && (st.baud_div == '0);
  endproperty
  a_baud_tick: assert property (p_baud_tick) else $error("baud tick missing at divider end"); // RULE11

  property p_first_ovf_pulse;
    @(posedge clock_in) disable iff (sys_rst_in)
      ovf0
      |=> first_timer_ovf_out && st.status.first_low_ovf;
  endproperty
  a_first_ovf_pulse: assert property (p_first_ovf_pulse) else $error("first overflow pulse lost"); // RULE12
endmodule

// file: tb/uart_baud_sink.sv
// uart side model: sets the uart mode and times the baud ticks it receives
// assumes baud ticks are one-cycle pulses synchronous to clock_in
module uart_baud_sink
  import timer_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic [1:0] mode_sel_in,
  input  wire logic       baud_tick_in,
  output logic [1:0]      uart_mode_out,
  output logic [31:0]     tick_count_out,
  output logic [31:0]     tick_gap_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] since;

  assign uart_mode_out = mode_sel_in;

  // cycles between the last two ticks
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      since          <= 32'h0;
      tick_count_out <= 32'h0;
      tick_gap_out   <= 32'h0;
    end else if (baud_tick_in === 1'b1) begin
      since          <= 32'h1;
      tick_count_out <= tick_count_out + 32'h1;
      tick_gap_out   <= since;
    end else begin
      since <= since + 32'h1;
    end
  end
endmodule

// file: tb/tb.sv
// self-checking bench of the dual timer block, random reloads and corner cases
// assumes a single ahb-lite slave whose hreadyout is fed back as hready
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end

module tb
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic          clock_in, sys_rst_in, hsel, hwrite, hready, hresp, pin;
  logic [DW-1:0] haddr, hwdata, hrdata;
  logic [1:0]    htrans, mode_sel, uart_mode;
  logic          irq, f_ovf, s_ovf, baud;
  logic [31:0]   tick_count, tick_gap;
  int unsigned   cyc, f_cnt, s_cnt, error_cnt, check_count;
  int unsigned   f_t[2], s_t[2];

  dual_timer_counter_baud uut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .first_timer_count_pin_in(pin), .uart_mode_in(uart_mode), .irq_out(irq),
    .first_timer_ovf_out(f_ovf), .second_timer_ovf_out(s_ovf), .baud_tick_out(baud)
  );

  uart_baud_sink sink (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .mode_sel_in(mode_sel), .baud_tick_in(baud),
    .uart_mode_out(uart_mode), .tick_count_out(tick_count), .tick_gap_out(tick_gap)
  );

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // pulse times and hang guard
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (f_ovf === 1'b1) begin
      f_cnt  <= f_cnt + 1;
      f_t[0] <= cyc;
      f_t[1] <= f_t[0];
    end
    if (s_ovf === 1'b1) begin
      s_cnt  <= s_cnt + 1;
      s_t[0] <= cyc;
      s_t[1] <= s_t[0];
    end
    if (cyc == 90000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic cycles(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // one single ahb-lite transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_in);
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clock_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock_in); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  // f holds {double, baud source, pin, run second, run first}
  function automatic logic [31:0] ctl(input logic [1:0] m1, input logic [1:0] m2, input logic [4:0] f);
    return {23'h0, f, m2, m1};
  endfunction

  initial begin
    logic [31:0] r;
    logic [7:0]  r1, r2;
    int unsigned b, c;
    sys_rst_in = 1'b1;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    pin = 1'b1;
    mode_sel = 2'h0;
    cyc = 0;
    f_cnt = 0;
    s_cnt = 0;
    error_cnt = 0;
    check_count = 0;
    void'($urandom(46570));
    repeat (3) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    // unmapped place and stopped timer after reset
    wr(8'h40, 32'hffffffff);
    rd(8'h40, r);
    `CHK(r, 32'h0)
    `CHK(hresp, 1'b0)
    rd(OFS_FIRST_LOW, r);
    `CHK(r, 32'h0)
    // both timers in auto-reload with random reloads
    for (int i = 0; i < 3; i++) begin
      r1 = 8'($urandom_range(128, 253));
      r2 = 8'($urandom_range(128, 253));
      wr(OFS_FIRST_HI, {24'h0, r1});
      wr(OFS_FIRST_LOW, {24'h0, r1});
      wr(OFS_SECOND_RL, {24'h0, r2});
      wr(OFS_SECOND_LO, {24'h0, r2});
      b = f_cnt;
      c = s_cnt;
      wr(OFS_CTRL, ctl(MODE_RELOAD, MODE_RELOAD, 5'h03));
      wait (f_cnt >= b + 3 && s_cnt >= c + 3);
      `CHK(f_t[0] - f_t[1], 2 * (256 - r1))
      `CHK(s_t[0] - s_t[1], 2 * (256 - r2))
      wr(OFS_CTRL, 32'h0);
    end
    // 13-bit first timer beside reloading second timer
    wr(OFS_FIRST_LOW, 32'h0);
    wr(OFS_FIRST_HI, 32'h0);
    wr(OFS_SECOND_LO, {24'h0, r2});
    b = f_cnt;
    wr(OFS_CTRL, ctl(MODE_13BIT, MODE_RELOAD, 5'h03));
    wait (f_cnt >= b + 2);
    `CHK(f_t[0] - f_t[1], 2 * 32 * 256)
    `CHK(s_t[0] - s_t[1], 2 * (256 - r2))
    wr(OFS_CTRL, 32'h0);
    // 16-bit wrap to zero
    wr(OFS_FIRST_HI, 32'hff);
    wr(OFS_FIRST_LOW, 32'hf0);
    wr(OFS_SECOND_LO, 32'hf8);
    b = f_cnt;
    wr(OFS_CTRL, ctl(MODE_16BIT, MODE_16BIT, 5'h03));
    wait (f_cnt >= b + 1);
    wr(OFS_CTRL, ctl(MODE_16BIT, MODE_16BIT, 5'h00));
    rd(OFS_FIRST_HI, r);
    `CHK(r[7:0], 8'h00)
    rd(OFS_FIRST_LOW, r);
    `CHK(r[7:0] < 8'h10, 1'b1)
    // split mode: high byte alone, second timer frozen, interrupt path
    wr(OFS_STATUS, 32'hf);
    wr(OFS_FIRST_LOW, 32'h0);
    wr(OFS_FIRST_HI, 32'hf0);
    wr(OFS_SECOND_LO, 32'h5a);
    wr(OFS_MASK, 32'h2);
    b = f_cnt;
    c = s_cnt;
    wr(OFS_CTRL, ctl(MODE_SPLIT, MODE_SPLIT, 5'h02));
    wait (f_cnt >= b + 2);
    `CHK(f_t[0] - f_t[1], 2 * 256)
    rd(OFS_STATUS, r);
    `CHK(r, 32'h2)
    `CHK(irq, 1'b1)
    rd(OFS_FIRST_LOW, r);
    `CHK(r, 32'h0)
    rd(OFS_SECOND_LO, r);
    `CHK(r, 32'h5a)
    `CHK(s_cnt, c)
    wr(OFS_MASK, 32'h0);
    wr(OFS_CTRL, 32'h0);
    `CHK(irq, 1'b0)
    wr(OFS_STATUS, 32'h2);
    rd(OFS_STATUS, r);
    `CHK(r, 32'h0)
    // pin counting: four falls overflow a reload of fc
    wr(OFS_FIRST_HI, 32'hfc);
    wr(OFS_FIRST_LOW, 32'hfc);
    b = f_cnt;
    wr(OFS_CTRL, ctl(MODE_RELOAD, MODE_13BIT, 5'h07));
    for (int i = 0; i < 4; i++) begin
      pin <= 1'b0;
      cycles($urandom_range(1, 4));
      pin <= 1'b1;
      cycles($urandom_range(2, 6));
      if (i == 2) `CHK(f_cnt, b)
    end
    cycles(3);
    `CHK(f_cnt, b + 1)
    wr(OFS_CTRL, 32'h0);
    // baud ticks from second timer over every uart mode and both rates
    r2 = 8'($urandom_range(248, 254));
    wr(OFS_SECOND_RL, {24'h0, r2});
    wr(OFS_SECOND_LO, {24'h0, r2});
    for (int d = 0; d < 2; d++) begin
      for (int u = 0; u < 4; u++) begin
        mode_sel <= u[1:0];
        b = tick_count;
        wr(OFS_CTRL, ctl(MODE_13BIT, MODE_RELOAD, {d[0], 4'ha}));
        if (u == 1 || u == 3) begin
          wait (tick_count >= b + 3);
          `CHK(tick_gap, 32'((d == 1 ? 16 : 32) * 2 * (256 - r2)))
        end else begin
          cycles(1200);
          `CHK(tick_count, 32'(b))
        end
        wr(OFS_CTRL, 32'h0);
      end
    end
    // variable-rate uart mode but baud source not selected
    mode_sel <= 2'h1;
    b = tick_count;
    wr(OFS_CTRL, ctl(MODE_13BIT, MODE_RELOAD, 5'h02));
    cycles(1200);
    `CHK(tick_count, 32'(b))
    stop_test();
  end
endmodule
